// [include/monitor_cfg_pkg.sv]
// constants for the monitor configuration register bank
package monitor_cfg_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0]  GENERAL_SETUP_OFFS   = 8'h00;
  localparam logic [7:0]  CONVERTER_SETUP_OFFS = 8'h01;
  localparam logic [15:0] GENERAL_SETUP_RESET  = 16'h0000;
  localparam logic [15:0] CONVERTER_SETUP_RESET = 16'hfb68;
  // ==========================================================
  // general setup fields
  localparam int RESET_BIT          = 15;
  localparam int START_DELAY_LSB    = 6;
  localparam int START_DELAY_MSB    = 13;
  localparam int SHUNT_RANGE_BIT    = 4;
  localparam logic [15:0] GENERAL_SETUP_MASK = 16'h3fd0;
  // ==========================================================
  // converter setup fields
  localparam int MODE_LSB           = 12;
  localparam int MODE_MSB           = 15;
  localparam int BUS_CT_LSB         = 9;
  localparam int BUS_CT_MSB         = 11;
  localparam logic [3:0] MODE_CONT_BIT = 4'h8;
  // ==========================================================
  // timing
  localparam int CLOCK_MHZ          = 100;
  localparam int DELAY_STEP_MS      = 2;
  localparam int DELAY_STEP_CYCLES  = DELAY_STEP_MS * 1000 * 1000 * CLOCK_MHZ / 1000;
  localparam int CT_US_0 = 50;
  localparam int CT_US_1 = 84;
  localparam int CT_US_2 = 150;
  localparam int CT_US_3 = 280;
  localparam int CT_US_4 = 540;
  localparam int CT_US_5 = 1052;
  localparam int CT_US_6 = 2074;
  localparam int CT_US_7 = 4120;
  // shunt result weight in nanovolts per count
  localparam logic [15:0] SHUNT_LSB_NV_WIDE   = 16'h1388;
  localparam logic [15:0] SHUNT_LSB_NV_NARROW = 16'h04e2;

  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_DELAY = 2'b01,
    SEQ_CONV  = 2'b10
  } seq_state_t;
endpackage

// [src/cycle_timer.sv]
// down counter that pulses when a loaded count expires
`timescale 1ns/1ps
module cycle_timer (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_b,
  // control
  input  wire logic        i_load,
  input  wire logic [31:0] i_count,
  // status
  output logic             o_busy,
  output logic             o_done
);
  logic [31:0] count_reg;

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count_reg <= 32'h0;
    end else if (i_load) begin
      count_reg <= i_count;
    end else if (count_reg != 32'h0) begin
      count_reg <= count_reg - 32'h1;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_done <= 1'b0;
    end else begin
      o_done <= !i_load && (count_reg == 32'h1);
    end
  end

  assign o_busy = (count_reg != 32'h0);
endmodule

// [src/monitor_config_registers.sv]
// configuration registers and conversion sequencing of the power monitor
`timescale 1ns/1ps
import monitor_cfg_pkg::*;
// Contract
// R1: writing one to bit 15 resets everything; bit self-clears; zero ignored
// R2: general setup bits 14, 5 and 3..0 always read zero
// R3: start delay field times 2 ms delays the first conversion
// R4: bit 4 selects wide (zero) or narrow (one) shunt range
// R5: mode bits 15..12; 0h and 8h are shutdown; resets to Fh
// R6: codes 1h..7h run one pass of the selected channels
// R7: codes 9h..Fh repeat passes of the selected channels
// R8: bus conversion time field 11..9 picks duration; resets to 5h
// R9: converter setup resets to fb68h
// R10: general setup resets to zero
// R11: shutdown starts no conversion and keeps stored results
// R12: sixteen-bit words move most significant byte first
// R13: shunt result weight is 5 uV wide, 1.25 uV narrow
module monitor_config_registers import monitor_cfg_pkg::*; (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_b,
  // register port from the serial engine, one byte per strobe
  input  wire logic [7:0]  i_pointer,
  input  wire logic        i_wr_byte,
  input  wire logic [7:0]  i_wr_data,
  input  wire logic        i_rd_byte,
  input  wire logic        i_frame_start,
  output logic [7:0]       o_rd_data,
  // conversion side
  output logic             o_conv_start,
  output logic [2:0]       o_conv_channels,
  output logic [31:0]      o_conv_cycles,
  output logic             o_shunt_range_select,
  output logic [15:0]      o_shunt_lsb_nv,
  output logic             o_pass_active,
  output logic             o_soft_reset
);
  // ==========================================================
  // registers
  logic [15:0] general_setup_reg;
  logic [15:0] converter_setup_reg;
  logic [7:0]  high_byte_reg;
  logic        byte_phase_reg;
  logic        soft_reset_reg;
  logic        config_written_reg;
  logic [15:0] word_next;
  logic        word_done;
  seq_state_t  state_reg;

  assign word_next = {high_byte_reg, i_wr_data};
  assign word_done = i_wr_byte && byte_phase_reg;

  // first byte is the high one, second completes the word
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      byte_phase_reg <= 1'b0;
      high_byte_reg  <= 8'h00;
    end else if (i_frame_start || soft_reset_reg) begin
      byte_phase_reg <= 1'b0;
    end else if (i_wr_byte || i_rd_byte) begin
      byte_phase_reg <= !byte_phase_reg; // R12
      if (i_wr_byte && !byte_phase_reg) begin
        high_byte_reg <= i_wr_data;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      soft_reset_reg <= 1'b0;
    end else begin
      soft_reset_reg <= word_done && (i_pointer == GENERAL_SETUP_OFFS)
                        && word_next[RESET_BIT]; // R1
    end
  end

  // ==========================================================
  // configuration storage; the reset bit is never stored, so it self-clears
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      general_setup_reg   <= GENERAL_SETUP_RESET; // R10
      converter_setup_reg <= CONVERTER_SETUP_RESET; // R9
      config_written_reg  <= 1'b0;
    end else if (soft_reset_reg) begin
      general_setup_reg   <= GENERAL_SETUP_RESET; // R1
      converter_setup_reg <= CONVERTER_SETUP_RESET; // R1
      config_written_reg  <= 1'b0;
    end else begin
      config_written_reg <= 1'b0;
      if (word_done && i_pointer == GENERAL_SETUP_OFFS && !word_next[RESET_BIT]) begin
        general_setup_reg <= word_next & GENERAL_SETUP_MASK; // R2
      end
      if (word_done && i_pointer == CONVERTER_SETUP_OFFS) begin
        converter_setup_reg <= word_next; // R5
        config_written_reg  <= 1'b1;
      end
    end
  end

  // read path: high byte first
  always_comb begin
    logic [15:0] word;
    word = 16'h0000;
    case (i_pointer)
      GENERAL_SETUP_OFFS:   word = general_setup_reg & GENERAL_SETUP_MASK; // R2
      CONVERTER_SETUP_OFFS: word = converter_setup_reg;
      default:              word = 16'h0000;
    endcase
    o_rd_data = byte_phase_reg ? word[7:0] : word[15:8]; // R12
  end

  // ==========================================================
  // conversion sequencing
  logic [3:0]  mode;
  logic [2:0]  bus_ct;
  logic [7:0]  start_delay_field;
  logic        shutdown;
  logic        delay_done;
  logic        conv_done;
  logic        delay_load;
  logic        delay_busy;
  logic [31:0] delay_count;

  assign mode              = converter_setup_reg[MODE_MSB:MODE_LSB];
  assign bus_ct            = converter_setup_reg[BUS_CT_MSB:BUS_CT_LSB];
  assign start_delay_field = general_setup_reg[START_DELAY_MSB:START_DELAY_LSB];
  assign shutdown          = (mode[2:0] == 3'h0); // R5
  assign delay_count       = 32'(start_delay_field) * 32'(DELAY_STEP_CYCLES); // R3

  always_comb begin
    case (bus_ct) // R8
      3'h0:    o_conv_cycles = 32'(CT_US_0 * CLOCK_MHZ);
      3'h1:    o_conv_cycles = 32'(CT_US_1 * CLOCK_MHZ);
      3'h2:    o_conv_cycles = 32'(CT_US_2 * CLOCK_MHZ);
      3'h3:    o_conv_cycles = 32'(CT_US_3 * CLOCK_MHZ);
      3'h4:    o_conv_cycles = 32'(CT_US_4 * CLOCK_MHZ);
      3'h5:    o_conv_cycles = 32'(CT_US_5 * CLOCK_MHZ);
      3'h6:    o_conv_cycles = 32'(CT_US_6 * CLOCK_MHZ);
      default: o_conv_cycles = 32'(CT_US_7 * CLOCK_MHZ);
    endcase
  end

  // a fresh config write or a reset restarts the pass after the start delay
  assign delay_load = !shutdown && (config_written_reg
                      || (state_reg == SEQ_IDLE && !o_pass_active));

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg     <= SEQ_IDLE;
      o_pass_active <= 1'b0;
    end else if (soft_reset_reg) begin
      state_reg     <= SEQ_IDLE;
      o_pass_active <= 1'b0;
    end else if (config_written_reg) begin
      state_reg     <= shutdown ? SEQ_IDLE : SEQ_DELAY; // R6
      o_pass_active <= !shutdown;
    end else begin
      case (state_reg)
        SEQ_IDLE: begin
          if (delay_load) begin
            state_reg     <= SEQ_DELAY;
            o_pass_active <= 1'b1;
          end
        end
        SEQ_DELAY: begin
          if (shutdown) begin
            state_reg <= SEQ_IDLE; // R11
          end else if (delay_done || !delay_busy) begin
            state_reg <= SEQ_CONV;
          end
        end
        SEQ_CONV: begin
          if (conv_done) begin
            state_reg <= (mode & MODE_CONT_BIT) != 4'h0 ? SEQ_CONV : SEQ_IDLE; // R7
          end
        end
        default: state_reg <= SEQ_IDLE;
      endcase
    end
  end

  cycle_timer i_cycle_timer_delay (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_load  (delay_load),
    .i_count (delay_count),
    .o_busy  (delay_busy),
    .o_done  (delay_done)
  );

  // conversions start entering the conversion state or, in continuous mode, after each finished one
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_conv_start <= 1'b0;
    end else begin
      o_conv_start <= !soft_reset_reg && !config_written_reg && !shutdown && ( // R11
                      (state_reg == SEQ_DELAY && (delay_done || !delay_busy)) ||
                      (state_reg == SEQ_CONV && conv_done &&
                       (mode & MODE_CONT_BIT) != 4'h0)); // R7
    end
  end

  cycle_timer i_cycle_timer_conv (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_load  (o_conv_start),
    .i_count (o_conv_cycles),
    .o_busy  (),
    .o_done  (conv_done)
  );

  assign o_conv_channels      = mode[2:0]; // R6
  assign o_shunt_range_select = general_setup_reg[SHUNT_RANGE_BIT]; // R4
  assign o_shunt_lsb_nv       = o_shunt_range_select ? SHUNT_LSB_NV_NARROW
                                                     : SHUNT_LSB_NV_WIDE; // R13
  assign o_soft_reset         = soft_reset_reg;

  // ==========================================================
  // checks
  a_reserved_zero: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (general_setup_reg & ~GENERAL_SETUP_MASK) == 16'h0000) // R2
    else $error("reserved bits set");
  a_soft_reset: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    soft_reset_reg |=> general_setup_reg == GENERAL_SETUP_RESET
    && converter_setup_reg == CONVERTER_SETUP_RESET) // R1
    else $error("soft reset did not restore defaults");
  a_rst_selfclear: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    soft_reset_reg |=> !soft_reset_reg) // R1
    else $error("reset bit did not clear");
  a_shutdown_idle: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    shutdown |=> !o_conv_start) // R11
    else $error("conversion started in shutdown");
  a_single_shot: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (state_reg == SEQ_CONV && conv_done && mode[3] == 1'b0 && !config_written_reg)
    |=> state_reg == SEQ_IDLE) // R6
    else $error("single shot repeated");
  a_continuous: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (state_reg == SEQ_CONV && conv_done && mode[3] && !shutdown
    && !soft_reset_reg && !config_written_reg) |=> o_conv_start) // R7
    else $error("continuous mode stopped");
  a_range_scale: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    o_shunt_lsb_nv == (general_setup_reg[SHUNT_RANGE_BIT] ? 16'h04e2 : 16'h1388)) // R13
    else $error("shunt scale mismatch");
  a_mode_write: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (word_done && i_pointer == CONVERTER_SETUP_OFFS && !soft_reset_reg)
    |=> converter_setup_reg == $past(word_next)) // R5
    else $error("converter setup write lost");
  a_conv_time: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    bus_ct == 3'h5 |-> o_conv_cycles == 32'd105200) // R8
    else $error("bus conversion time wrong");
  c_soft_reset: cover property (@(posedge i_clock) soft_reset_reg);
  c_single: cover property (@(posedge i_clock) o_conv_start && !mode[3]);
  c_cont: cover property (@(posedge i_clock) o_conv_start && mode[3]);
endmodule

// [testbench/host_byte_model.sv]
// byte-level register host standing in for the serial engine
`timescale 1ns/1ps
module host_byte_model (
  // clock
  input  wire logic       i_clock,
  // register port toward the bank
  output logic [7:0]      o_pointer,
  output logic            o_wr_byte,
  output logic [7:0]      o_wr_data,
  output logic            o_rd_byte,
  output logic            o_frame_start,
  input  wire logic [7:0] i_rd_data
);
  initial begin
    o_pointer     = 8'h00;
    o_wr_byte     = 1'b0;
    o_wr_data     = 8'h00;
    o_rd_byte     = 1'b0;
    o_frame_start = 1'b0;
  end

  // ==========================================================
  // frames
  // a start condition returns the byte phase to the high byte
  task automatic frame(input logic [7:0] ptr);
    @(posedge i_clock);
    o_pointer     <= ptr;
    o_frame_start <= 1'b1;
    @(posedge i_clock);
    o_frame_start <= 1'b0;
  endtask

  task automatic write_word(input logic [7:0] ptr, input logic [15:0] word);
    frame(ptr);
    o_wr_byte <= 1'b1;
    o_wr_data <= word[15:8];
    @(posedge i_clock);
    o_wr_data <= word[7:0];
    @(posedge i_clock);
    o_wr_byte <= 1'b0;
    // released data toggles so a stale byte never passes for a live one
    o_wr_data <= ~word[7:0];
    repeat (2) @(posedge i_clock);
  endtask

  task automatic read_word(input logic [7:0] ptr, output logic [15:0] word);
    frame(ptr);
    @(negedge i_clock);
    word[15:8] = i_rd_data;
    @(posedge i_clock);
    o_rd_byte <= 1'b1;
    @(posedge i_clock);
    o_rd_byte <= 1'b0;
    @(negedge i_clock);
    word[7:0] = i_rd_data;
  endtask
endmodule

// [testbench/test_monitor_config_registers.sv]
// self-checking bench for the monitor configuration register bank
`timescale 1ns/1ps
module test_monitor_config_registers import monitor_cfg_pkg::*;;
  logic        i_clock = 1'b0;
  logic        i_rst_b = 1'b0;
  logic [7:0]  pointer, wr_data, rd_data;
  logic        wr_byte, rd_byte, frame_start, conv_start, range_sel, pass_active, soft_reset;
  logic [2:0]  channels;
  logic [31:0] conv_cycles;
  logic [15:0] lsb_nv, word;
  int          err_total = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          starts = 0;
  int          resets = 0;
  int          base;
  int          ct_us [8] = '{CT_US_0, CT_US_1, CT_US_2, CT_US_3,
                             CT_US_4, CT_US_5, CT_US_6, CT_US_7};
  logic [3:0]  modes [4] = '{4'h0, 4'h8, 4'h1, 4'h9};
  int          lo [4] = '{0, 0, 1, 2};
  int          hi [4] = '{0, 0, 1, 4};

  always #5 i_clock = ~i_clock;

  host_byte_model i_host_byte_model (.i_clock(i_clock), .o_pointer(pointer),
    .o_wr_byte(wr_byte), .o_wr_data(wr_data), .o_rd_byte(rd_byte),
    .o_frame_start(frame_start), .i_rd_data(rd_data));

  monitor_config_registers i_monitor_config_registers (.i_clock(i_clock),
    .i_rst_b(i_rst_b), .i_pointer(pointer), .i_wr_byte(wr_byte),
    .i_wr_data(wr_data), .i_rd_byte(rd_byte), .i_frame_start(frame_start),
    .o_rd_data(rd_data), .o_conv_start(conv_start), .o_conv_channels(channels),
    .o_conv_cycles(conv_cycles), .o_shunt_range_select(range_sel),
    .o_shunt_lsb_nv(lsb_nv), .o_pass_active(pass_active), .o_soft_reset(soft_reset));

  // ==========================================================
  // monitors and timeout
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (conv_start === 1'b1) begin
      starts <= starts + 1;
    end
    if (soft_reset === 1'b1) begin
      resets <= resets + 1;
    end
    if (cycles == 70000) begin
      err_total++;
      end_of_test();
    end
  end

  // ==========================================================
  // tasks
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] p, input logic [15:0] w);
    i_host_byte_model.write_word(p, w);
  endtask

  task automatic rd(input logic [7:0] p, input logic [15:0] exp);
    i_host_byte_model.read_word(p, word);
    check({16'h0000, word}, {16'h0000, exp});
  endtask

  // ==========================================================
  // sequence
  initial begin
    repeat (20) @(posedge i_clock);
    i_rst_b <= 1'b1;
    @(posedge i_clock);
    rd(8'h00, 16'h0000);
    rd(8'h01, 16'hfb68);
    check(conv_cycles, CT_US_5 * 100);
    check({29'h0, channels}, 32'h7);
    check({16'h0, lsb_nv}, 32'h1388);
    check({31'h0, range_sel}, 32'h0);
    // zero in the reset bit is an ordinary write
    wr(8'h00, 16'h7fff);
    rd(8'h00, 16'h3fd0);
    rd(8'h01, 16'hfb68);
    check({31'h0, range_sel}, 32'h1);
    check({16'h0, lsb_nv}, 32'h04e2);
    wr(8'h02, 16'h1234);
    rd(8'h02, 16'h0000);
    rd(8'h00, 16'h3fd0);
    // start delay back to zero so passes begin at once
    wr(8'h00, 16'h0010);
    rd(8'h00, 16'h0010);
    for (int c = 0; c < 8; c++) begin
      wr(8'h01, {4'h0, c[2:0], 9'h000});
      check(conv_cycles, ct_us[c] * 100);
      check({29'h0, channels}, 32'h0);
    end
    for (int m = 1; m < 16; m++) begin
      wr(8'h01, {m[3:0], 12'h000});
      rd(8'h01, {m[3:0], 12'h000});
      check({29'h0, channels}, {29'h0, m[2:0]});
    end
    wr(8'h01, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      @(negedge i_clock);
      base = starts;
      wr(8'h01, {modes[k], 12'h000});
      repeat (12000) @(posedge i_clock);
      check({31'h0, starts - base >= lo[k] && starts - base <= hi[k]}, 32'h1);
    end
    // a one-step start delay holds the first conversion off for 2 ms
    wr(8'h00, 16'h0040);
    wr(8'h01, 16'h9000);
    @(negedge i_clock);
    base = starts;
    repeat (3000) @(posedge i_clock);
    check(starts - base, 32'h0);
    check({31'h0, pass_active}, 32'h1);
    wr(8'h01, 16'h1234);
    @(negedge i_clock);
    base = resets;
    // other fields of a reset write are never stored
    wr(8'h00, 16'h8050);
    check(resets - base, 32'h1);
    rd(8'h00, 16'h0000);
    rd(8'h01, 16'hfb68);
    check({31'h0, range_sel}, 32'h0);
    end_of_test();
  end
endmodule
